// *** design/qbp_defines.svh ***
// constants for the quasi-bidirectional port slice
// assumes a 200 MHz core clock
// What this block does
// - port three bits with latch one are held high only by pull-up
// - port three alternate functions assigned per bit as listed
// - port four bit 0 is can transmit, bit 1 feeds can receive
// - latch-write strobe captures bus data into the pin latch
// - read-latch strobe drives stored latch value onto the bus
// - read-pin strobe drives sampled pin level onto the bus
// - read-modify-write reads use latch path, other reads use the path rd_kind names
// - each line is input or output independently of the others
// - latch one switches off the strong low-side driver while the alternate output is one
// - with latch one, the pin follows the alternate output signal
// - a port one analog pin can have its pull-up disconnected
// - every reset sets all latch bits to one
// - latch updates at cycle end, pin changes in the next cycle
// - strong pull-up for 2 oscillator periods after a zero-to-one
// - analog channel config register selects analog pins, drops pull-up
`ifndef QBP_DEFINES_SVH
`define QBP_DEFINES_SVH
`define QBP_LATCH_RESET   8'hff
`define QBP_BOOST_NS      10
`define QBP_CLK_NS        5
`define QBP_BOOST_CYC     ((`QBP_BOOST_NS + `QBP_CLK_NS - 1) / `QBP_CLK_NS)
`define QBP_P3_RXD        0
`define QBP_P3_TXD        1
`define QBP_P3_IRQ0       2
`define QBP_P3_IRQ1       3
`define QBP_P3_T0         4
`define QBP_P4_CAN_TX     0
`define QBP_P4_CAN_RX     1
`endif

// *** design/qbp_pkg.sv ***
// types for the quasi-bidirectional port slice
// assumes nothing of its surroundings
package qbp_pkg;
  typedef enum logic [1:0] {
    QBP_RD_NONE,
    QBP_RD_LATCH,
    QBP_RD_PIN
  } qbp_rd_t;
endpackage : qbp_pkg

// *** design/qbp_bit.sv ***
// one pin: latch, drivers and strong pull-up timer
// assumes strobes and pin level synchronous to clk
`timescale 1ns/1ps
`default_nettype none
`include "qbp_defines.svh"
module qbp_bit #(
  parameter int BOOST_CYC = `QBP_BOOST_CYC
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic wr,
  input  wire logic din,
  input  wire logic alt_out,
  input  wire logic analog_sel,
  output logic      latch_q,
  output logic      drive_low,
  output logic      weak_pullup,
  output logic      strong_pullup
);
  logic       next_latch;
  logic [3:0] cnt;
  logic [3:0] next_cnt;

  always_comb begin
    next_latch = wr ? din : latch_q;
    next_cnt = (cnt != 4'h0) ? cnt - 4'h1 : 4'h0;
    if (!latch_q && next_latch) begin
      next_cnt = 4'(BOOST_CYC);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      latch_q <= 1'b1;
      cnt     <= 4'h0;
    end else begin
      latch_q <= next_latch;
      cnt     <= next_cnt;
    end
  end

  // low driver off when latch and alt output are both one; with latch one, alt output steers level
  assign drive_low     = ~(latch_q & alt_out);
  assign weak_pullup   = ~drive_low & ~analog_sel;
  assign strong_pullup = (cnt != 4'h0) & ~analog_sel;

  // analog pins keep the boost off, so only digital pins are held to it
  boost_len_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    ($rose(latch_q) && !analog_sel) |->
      strong_pullup[*2] ##1 !strong_pullup)
    else $error("boost not two cycles");
  low_drive_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    (wr && !din) |=> drive_low)
    else $error("low driver not on after zero write");
  latch_cap_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    wr |=> latch_q == $past(din))
    else $error("latch not captured");
endmodule : qbp_bit
`default_nettype wire

// *** design/qbp_port.sv ***
// quasi-bidirectional ports one, three and four with bus read paths
// assumes core strobes one cycle wide, synchronous to clk
`timescale 1ns/1ps
`default_nettype none
`include "qbp_defines.svh"
module qbp_port #(
  parameter int BOOST_CYC = `QBP_BOOST_CYC
) (
  input  wire logic          clk,
  input  wire logic          rst_n,
  input  wire logic [1:0]    port_sel,
  input  wire logic          latch_wr,
  input  wire logic [7:0]    bus_din,
  input  wire qbp_pkg::qbp_rd_t rd_kind,
  input  wire logic          rmw_rd,
  output logic [7:0]         bus_dout,
  output logic               bus_dout_en,
  input  wire logic [7:0]    analog_channel_config_register,
  input  wire logic [7:0]    port_one_alt_out,
  input  wire logic [7:0]    port_one_in,
  input  wire logic [7:0]    port_three_in,
  input  wire logic [1:0]    port_four_in,
  input  wire logic          serial_tx_out,
  input  wire logic          serial_rx_drive,
  input  wire logic          can_tx_out,
  output logic [7:0]         port_one_drive_low,
  output logic [7:0]         port_one_weak_pullup,
  output logic [7:0]         port_one_strong_pullup,
  output logic [7:0]         port_three_drive_low,
  output logic [7:0]         port_three_weak_pullup,
  output logic [7:0]         port_three_strong_pullup,
  output logic [1:0]         port_four_drive_low,
  output logic [1:0]         port_four_weak_pullup,
  output logic [1:0]         port_four_strong_pullup,
  output logic               serial_rx_in,
  output logic               external_irq_zero_pin,
  output logic               external_irq_one_pin,
  output logic               timer_zero_count_pin,
  output logic               can_receive_pin
);
  import qbp_pkg::*;
  localparam logic [1:0] SEL_ONE = 2'h1;
  localparam logic [1:0] SEL_THREE = 2'h3;
  localparam logic [1:0] SEL_FOUR = 2'h0;

  logic [17:0] latch_all;
  logic [17:0] alt_all;
  logic [17:0] wr_all;
  logic [17:0] din_all;
  logic [17:0] ana_all;
  logic [17:0] low_all;
  logic [17:0] weak_all;
  logic [17:0] strong_all;
  logic [7:0]  p3_alt;
  logic [1:0]  p4_alt;
  logic [7:0]  sel_latch;
  logic [7:0]  sel_pin;
  logic [7:0]  next_dout;
  logic        next_en;
  qbp_rd_t     eff_rd;

  always_comb begin
    p3_alt = 8'hff;
    p3_alt[`QBP_P3_RXD] = serial_rx_drive;
    p3_alt[`QBP_P3_TXD] = serial_tx_out;
    p4_alt = 2'h3;
    p4_alt[`QBP_P4_CAN_TX] = can_tx_out;
  end

  assign alt_all = {p4_alt, p3_alt, port_one_alt_out};
  assign din_all = {bus_din[1:0], bus_din, bus_din};
  assign wr_all = {{2{latch_wr && port_sel == SEL_FOUR}},
                   {8{latch_wr && port_sel == SEL_THREE}},
                   {8{latch_wr && port_sel == SEL_ONE}}};
  assign ana_all = {10'h000, analog_channel_config_register};

  // one slice per pin keeps every line independent
  genvar gi;
  generate
    for (gi = 0; gi < 18; gi++) begin : g_bit
      qbp_bit #(.BOOST_CYC(BOOST_CYC)) u_bit (
        .clk           (clk),
        .rst_n         (rst_n),
        .wr            (wr_all[gi]),
        .din           (din_all[gi]),
        .alt_out       (alt_all[gi]),
        .analog_sel    (ana_all[gi]),
        .latch_q       (latch_all[gi]),
        .drive_low     (low_all[gi]),
        .weak_pullup   (weak_all[gi]),
        .strong_pullup (strong_all[gi])
      );
    end
  endgenerate

  assign port_one_drive_low       = low_all[7:0];
  assign port_one_weak_pullup     = weak_all[7:0];
  assign port_one_strong_pullup   = strong_all[7:0];
  assign port_three_drive_low     = low_all[15:8];
  assign port_three_weak_pullup   = weak_all[15:8];
  assign port_three_strong_pullup = strong_all[15:8];
  assign port_four_drive_low      = low_all[17:16];
  assign port_four_weak_pullup    = weak_all[17:16];
  assign port_four_strong_pullup  = strong_all[17:16];

  // inputs to peripherals come from the pin; latch one lets them through
  assign serial_rx_in          = port_three_in[`QBP_P3_RXD];
  assign external_irq_zero_pin = port_three_in[`QBP_P3_IRQ0];
  assign external_irq_one_pin  = port_three_in[`QBP_P3_IRQ1];
  assign timer_zero_count_pin  = port_three_in[`QBP_P3_T0];
  assign can_receive_pin       = port_four_in[`QBP_P4_CAN_RX];

  always_comb begin
    eff_rd = rd_kind;
    if (rmw_rd) begin
      eff_rd = QBP_RD_LATCH;
    end
    unique case (port_sel)
      SEL_ONE: begin
        sel_latch = latch_all[7:0];
        sel_pin   = port_one_in;
      end
      SEL_THREE: begin
        sel_latch = latch_all[15:8];
        sel_pin   = port_three_in;
      end
      SEL_FOUR: begin
        sel_latch = {6'h00, latch_all[17:16]};
        sel_pin   = {6'h00, port_four_in};
      end
      default: begin
        sel_latch = 8'h00;
        sel_pin   = 8'h00;
      end
    endcase
    next_en = 1'b1;
    unique case (eff_rd)
      QBP_RD_LATCH: next_dout = sel_latch;
      QBP_RD_PIN:   next_dout = sel_pin;
      default: begin
        next_dout = 8'h00;
        next_en   = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_dout    <= 8'h00;
      bus_dout_en <= 1'b0;
    end else begin
      bus_dout    <= next_dout;
      bus_dout_en <= next_en;
    end
  end

  // read paths: the answer stands one cycle after the strobe
  rd_latch_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    (rmw_rd && port_sel == SEL_THREE) |=>
      bus_dout == $past(latch_all[15:8]))
    else $error("rmw read not from latch");

  rd_pin_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    (!rmw_rd && rd_kind == QBP_RD_PIN && port_sel == SEL_ONE)
    |=> bus_dout == $past(port_one_in))
    else $error("pin read mismatch");

  latch_rd_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    (!rmw_rd && rd_kind == QBP_RD_LATCH && port_sel == SEL_THREE)
    |=> bus_dout == $past(latch_all[15:8]))
    else $error("latch read mismatch");

  p4_pin_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    (!rmw_rd && rd_kind == QBP_RD_PIN && port_sel == SEL_FOUR)
    |=> bus_dout == {6'h00, $past(port_four_in)})
    else $error("port four pin read mismatch");

  rd_en_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    (rd_kind == QBP_RD_LATCH || rd_kind == QBP_RD_PIN || rmw_rd)
    |=> bus_dout_en)
    else $error("read answer missing");

  rd_idle_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    (rd_kind == QBP_RD_NONE && !rmw_rd) |=>
      (!bus_dout_en && bus_dout == 8'h00))
    else $error("bus driven without a read");

  // latches change only on a write to their own port
  p4_write_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    (latch_wr && port_sel == SEL_FOUR) |=>
      latch_all[17:16] == $past(bus_din[1:0]))
    else $error("port four latch not written");

  p3_hold_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    !(latch_wr && port_sel == SEL_THREE) |=>
      latch_all[15:8] == $past(latch_all[15:8]))
    else $error("port three latch moved without write");

  // pin drivers against latch and alternate outputs
  p3_quasi_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    latch_all[15] |->
      (!port_three_drive_low[7] && port_three_weak_pullup[7]))
    else $error("quasi input not pulled up");

  p3_low_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    !latch_all[8] |-> port_three_drive_low[0])
    else $error("low driver off with latch zero");

  p3_txd_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    latch_all[9] |-> port_three_drive_low[1] == !serial_tx_out)
    else $error("serial transmit not on pin");

  p3_plain_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    latch_all[14] |-> !port_three_drive_low[6])
    else $error("plain pin driven low with latch one");

  p1_alt_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    latch_all[0] |-> port_one_drive_low[0] == !port_one_alt_out[0])
    else $error("port one alternate output not on pin");

  can_tx_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    latch_all[16] |-> port_four_drive_low[0] == !can_tx_out)
    else $error("can transmit not on pin");

  // analog pins lose both pull-ups
  ana_pull_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    analog_channel_config_register[0] |-> !port_one_weak_pullup[0])
    else $error("analog pull-up on");

  ana_boost_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    analog_channel_config_register[0] |-> !port_one_strong_pullup[0])
    else $error("analog boost on");
endmodule : qbp_port
`default_nettype wire

// *** testbench/qbp_pins.sv ***
// external pin model: resolves pin level from drivers, pull-ups and loads
// assumes drive_low and pull come straight from the port slice
`timescale 1ns/1ps
`default_nettype none
module qbp_pins #(
  parameter int W = 8
) (
  input  wire logic [W-1:0] drive_low,
  input  wire logic [W-1:0] pull,
  input  wire logic [W-1:0] ext_low,
  output logic [W-1:0]      pin
);
  // a pin with no pull and no driver is taken as low
  always_comb pin = ~(drive_low | ext_low) & pull;
endmodule : qbp_pins
`default_nettype wire

// *** testbench/tb_top.sv ***
// self-checking bench for the quasi-bidirectional port slice
// assumes qbp_pkg and qbp_port compiled before this file
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import qbp_pkg::*;
  logic clk = 0, rst_n = 0, latch_wr = 0, rmw_rd = 0, tx = 1, ctx = 1;
  logic [1:0] port_sel = 2'h2, p4_ext = 2'h0;
  logic [7:0] bus_din = 8'h00, acr = 8'h00, p1_ext = 8'h00, p3_ext = 8'h00;
  logic [7:0] p1_alt = 8'hff;
  logic       rxd = 1;
  logic [7:0] got;
  qbp_rd_t    rd_kind = QBP_RD_NONE;
  wire logic [7:0] dout, p1_dl, p1_wp, p1_sp, p3_dl, p3_wp, p3_sp, p1_in, p3_in;
  wire logic [1:0] p4_dl, p4_wp, p4_sp, p4_in;
  wire logic       en, srx, irq0, irq1, t0, crx;
  int mismatches = 0;
  int num_checks = 0;
  always #2.5 clk = ~clk;
  qbp_port #(.BOOST_CYC(2)) dut (.clk(clk), .rst_n(rst_n),
    .port_sel(port_sel), .latch_wr(latch_wr), .bus_din(bus_din),
    .rd_kind(rd_kind), .rmw_rd(rmw_rd), .bus_dout(dout), .bus_dout_en(en),
    .analog_channel_config_register(acr), .port_one_alt_out(p1_alt),
    .port_one_in(p1_in), .port_three_in(p3_in), .port_four_in(p4_in),
    .serial_tx_out(tx), .serial_rx_drive(rxd), .can_tx_out(ctx),
    .port_one_drive_low(p1_dl), .port_one_weak_pullup(p1_wp),
    .port_one_strong_pullup(p1_sp), .port_three_drive_low(p3_dl),
    .port_three_weak_pullup(p3_wp), .port_three_strong_pullup(p3_sp),
    .port_four_drive_low(p4_dl), .port_four_weak_pullup(p4_wp),
    .port_four_strong_pullup(p4_sp), .serial_rx_in(srx),
    .external_irq_zero_pin(irq0), .external_irq_one_pin(irq1),
    .timer_zero_count_pin(t0), .can_receive_pin(crx));
  qbp_pins #(.W(8)) m1 (.drive_low(p1_dl), .pull(p1_wp | p1_sp),
    .ext_low(p1_ext), .pin(p1_in));
  qbp_pins #(.W(8)) m3 (.drive_low(p3_dl), .pull(p3_wp | p3_sp),
    .ext_low(p3_ext), .pin(p3_in));
  qbp_pins #(.W(2)) m4 (.drive_low(p4_dl), .pull(p4_wp | p4_sp),
    .ext_low(p4_ext), .pin(p4_in));
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    num_checks++;
    if (g !== e) begin
      mismatches++;
      $display("Error t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic wr(input logic [1:0] s, input logic [7:0] d);
    @(posedge clk) #1;
    port_sel = s; bus_din = d; latch_wr = 1;
    @(posedge clk) #1;
    latch_wr = 0;
  endtask : wr
  task automatic rd(input logic [1:0] s, input qbp_rd_t k, input logic r);
    @(posedge clk) #1;
    port_sel = s; rd_kind = k; rmw_rd = r;
    @(posedge clk) #1;
    rd_kind = QBP_RD_NONE; rmw_rd = 0; got = dout;
    chk({7'h00, en}, 8'h01);
  endtask : rd
  task automatic t_reset;
    chk({7'h00, en}, 8'h00);
    chk(p3_dl, 8'h00);
    chk(p3_in, 8'hff);
    chk(p3_sp, 8'h00);
    chk({4'h0, t0, irq1, irq0, srx}, 8'h0f);
    rd(2'h3, QBP_RD_LATCH, 0); chk(got, 8'hff);
    $display("reset test done");
  endtask : t_reset
  task automatic t_write;
    wr(2'h3, 8'hfe); chk(p3_dl, 8'h01);
    chk(p3_in, 8'hfe);
    chk(p3_wp, 8'hfe);
    rd(2'h3, QBP_RD_LATCH, 0); chk(got, 8'hfe);
    wr(2'h3, 8'hff); chk(p3_sp, 8'h01);
    @(posedge clk) #1; chk(p3_sp, 8'h01);
    @(posedge clk) #1; chk(p3_sp, 8'h00);
    chk(p3_dl, 8'h00);
    $display("write test done");
  endtask : t_write
  task automatic t_read;
    p3_ext = 8'h1f;
    rd(2'h3, QBP_RD_PIN, 0); chk(got, 8'he0);
    rd(2'h3, QBP_RD_PIN, 1); chk(got, 8'hff);
    chk({4'h0, t0, irq1, irq0, srx}, 8'h00);
    p3_ext = 8'h00; p1_ext = 8'h3c;
    rd(2'h1, QBP_RD_PIN, 0); chk(got, 8'hc3);
    p1_ext = 8'h00;
    rd(2'h2, QBP_RD_LATCH, 0); chk(got, 8'h00);
    $display("read test done");
  endtask : t_read
  task automatic t_alt;
    tx = 0; rxd = 0; @(posedge clk) #1;
    chk(p3_dl, 8'h03);
    tx = 1; rxd = 1; ctx = 0; @(posedge clk) #1;
    chk({6'h00, p4_dl}, 8'h01);
    ctx = 1; p4_ext = 2'h2; @(posedge clk) #1;
    chk({7'h00, crx}, 8'h00);
    rd(2'h0, QBP_RD_PIN, 0); chk(got, 8'h01);
    p4_ext = 2'h0; p1_alt = 8'hef; @(posedge clk) #1;
    chk(p1_dl, 8'h10);
    p1_alt = 8'hff;
    wr(2'h0, 8'hfd); chk({6'h00, p4_dl}, 8'h02);
    chk({6'h00, p4_wp}, 8'h01);
    wr(2'h0, 8'hff); chk({6'h00, p4_sp}, 8'h02);
    $display("alternate test done");
  endtask : t_alt
  task automatic t_analog;
    acr = 8'h81; @(posedge clk) #1;
    chk(p1_wp, 8'h7e);
    wr(2'h1, 8'h00); wr(2'h1, 8'hff);
    chk(p1_sp, 8'h7e);
    acr = 8'h00; @(posedge clk) #1;
    chk(p1_wp, 8'hff);
    $display("analog test done");
  endtask : t_analog
  task automatic t_rerst;
    wr(2'h3, 8'h00); chk(p3_dl, 8'hff);
    rst_n = 0; @(posedge clk) #1;
    chk(p3_dl, 8'h00);
    chk(p3_sp, 8'h00);
    rst_n = 1; @(posedge clk) #1;
    chk(p3_sp, 8'h00);
    rd(2'h3, QBP_RD_LATCH, 0); chk(got, 8'hff);
    $display("second reset test done");
  endtask : t_rerst
  task automatic conclude;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : conclude
  initial begin
    #20000;
    mismatches++;
    conclude();
  end
  initial begin
    repeat (16) @(posedge clk);
    #1 rst_n = 1;
    t_reset(); t_write(); t_read(); t_alt(); t_analog(); t_rerst();
    conclude();
  end
endmodule : tb_top
`default_nettype wire
